// *** bea_ctrl.sv ***
`timescale 1ns/10ps
module bea_ctrl
	import bea_pkg::*;
#(
	parameter int DEPTH      = 64,          // store size in bytes
	parameter int ATOMIC_LEN = ATOMIC_CYC,  // atomic programming cycles
	parameter int SPLIT_LEN  = SPLIT_CYC    // erase-only / write-only cycles
) (
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,   // core reset, async low
	input  wire logic       por_n_i,    // power-on reset, async low
	input  wire logic [1:0] addr_i,     // register offset
	input  wire logic [7:0] wdata_i,    // write data
	input  wire logic       wr_i,       // write strobe
	input  wire logic       rd_i,       // read strobe
	output logic      [7:0] rdata_o,    // read data, one cycle later
	output logic            stall_o,    // core halt request
	output logic            irq_o       // ready interrupt level
);
	//--------------------------------------------------------------------------
	// parameters and checks
	//--------------------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam int TW = 17;

	initial begin
		if (DEPTH != 64) $error("store depth must be 64");
		if (ATOMIC_LEN < 2 || ATOMIC_LEN >= (1 << TW)) $error("bad atomic length");
		if (SPLIT_LEN < 2 || SPLIT_LEN >= (1 << TW)) $error("bad split length");
	end

	//--------------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------------
	logic [7:0]    mem [DEPTH];     // the byte store (RQ1)
	logic [AW-1:0] store_address_reg;
	logic [7:0]    store_data_reg;
	logic [1:0]    program_mode_field;
	logic          ready_irq_enable;
	logic          arm;             // arm bit
	logic [2:0]    arm_cnt;         // cycles left before arm lapses
	logic          program_strobe;  // busy indication
	logic [1:0]    op_mode;         // latched mode of running op
	logic [AW-1:0] op_addr;         // latched address of running op
	logic [7:0]    op_data;         // latched data of running op
	logic          tmr_busy;        // timer still counting
	logic          tmr_done;        // last cycle of the timed op

	// decoded control write
	logic          wr_ctrl;         // write to the control register
	logic          launch;          // a legal, armed program strobe
	logic          rd_go;           // an accepted read strobe
	logic [TW-1:0] op_len;          // length of the op about to start

	// offset match, used for every register
	function automatic logic is_ofs(input logic [1:0] a, input logic [1:0] o);
		return a == o;
	endfunction

	// one decode shared by every control field; bits 7:6 are dropped
	assign wr_ctrl = wr_i && is_ofs(addr_i, CTRL_OFS);
	// armed strobe, idle, legal mode launches (RQ7 RQ10 RQ12 RQ17 RQ20 RQ9)
	assign launch  = wr_ctrl && wdata_i[PROG_BIT] && arm && !program_strobe
	                 && (program_mode_field != MODE_RESERVE);
	// read refused while busy (RQ9)
	assign rd_go   = wr_ctrl && wdata_i[READ_BIT] && !program_strobe;

	//--------------------------------------------------------------------------
	// address and data registers (RQ2)
	//--------------------------------------------------------------------------
	// address register; frozen while busy (RQ9)
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			store_address_reg <= '0;
		end else if (wr_i && is_ofs(addr_i, ADDR_OFS) && !program_strobe) begin
			store_address_reg <= wdata_i[AW-1:0];   // RQ2
		end
	end

	// data register; a read loads it at once (RQ18)
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			store_data_reg <= ZERO_BYTE;
		end else if (rd_go) begin
			store_data_reg <= mem[store_address_reg];  // RQ18
		end else if (wr_i && is_ofs(addr_i, DATA_OFS)) begin
			store_data_reg <= wdata_i;
		end
	end

	//--------------------------------------------------------------------------
	// control register
	//--------------------------------------------------------------------------
	// mode field: ignored while busy, kept across reset while busy
	always_ff @(posedge mclk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			program_mode_field <= MODE_ATOMIC;
		end else if (!resetn_i && !program_strobe) begin
			program_mode_field <= MODE_ATOMIC;      // RQ15
		end else if (wr_ctrl && !program_strobe) begin
			program_mode_field <= wdata_i[MODE_HI:MODE_LO];
		end
	end

	// interrupt enable
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ready_irq_enable <= 1'b0;
		end else if (wr_ctrl) begin
			ready_irq_enable <= wdata_i[IRQE_BIT];
		end
	end

	// arm bit clears itself four cycles after set (RQ17)
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			arm     <= 1'b0;
			arm_cnt <= '0;
		end else if (wr_ctrl && wdata_i[ARM_BIT]) begin
			arm     <= 1'b1;
			arm_cnt <= 3'(ARM_CYC);
		end else if (launch) begin
			arm     <= 1'b0;                    // used up by the launch
			arm_cnt <= '0;
		end else if (arm_cnt != '0) begin
			arm_cnt <= arm_cnt - 3'(1);
			arm     <= (arm_cnt != 3'(1));      // RQ17
		end
	end

	//--------------------------------------------------------------------------
	// programming sequencer; survives core reset (RQ15)
	//--------------------------------------------------------------------------
	always_comb begin
		unique case (program_mode_field)
			MODE_ATOMIC: op_len = TW'(ATOMIC_LEN);   // RQ16
			MODE_ERASE:  op_len = TW'(SPLIT_LEN);    // RQ16
			MODE_WRITE:  op_len = TW'(SPLIT_LEN);    // RQ16
			MODE_RESERVE: op_len = '0;
		endcase
	end

	// latch operation and hold the strobe until the timer ends (RQ8 RQ11 RQ12 RQ3)
	always_ff @(posedge mclk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			program_strobe <= 1'b0;
			op_mode        <= MODE_ATOMIC;
			op_addr        <= '0;
			op_data        <= ZERO_BYTE;
		end else if (launch && resetn_i) begin
			program_strobe <= 1'b1;             // RQ3
			op_mode        <= program_mode_field;
			op_addr        <= store_address_reg;
			op_data        <= store_data_reg;
		end else if (tmr_done) begin
			program_strobe <= 1'b0;             // RQ8 RQ11
		end
	end

	// the timer sits on power-on reset only, so a core reset cannot cut an op short
	bea_timer #(.W(TW)) u_timer (
		.mclk_i  (mclk_i),
		.por_n_i (por_n_i),
		.start_i (launch && resetn_i),
		.cycles_i(op_len),
		.busy_o  (tmr_busy),
		.done_o  (tmr_done)
	);

	// the store has no reset: cells keep their contents over both resets
	// store update at the end of the operation (RQ1 RQ7 RQ10 RQ12)
	always_ff @(posedge mclk_i) begin
		if (tmr_done && program_strobe) begin
			unique case (op_mode)
				MODE_ATOMIC: mem[op_addr] <= op_data;                   // RQ7
				MODE_ERASE:  mem[op_addr] <= ERASED_BYTE;               // RQ10
				MODE_WRITE:  mem[op_addr] <= mem[op_addr] & op_data;    // RQ12
				MODE_RESERVE: mem[op_addr] <= mem[op_addr];             // RQ20
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// core stall (RQ4 RQ5)
	//--------------------------------------------------------------------------
	// a read and a launch in one write take the longer read stall
	bea_stall #(.W(3)) u_stall (
		.mclk_i  (mclk_i),
		.resetn_i(resetn_i),
		.load_i  (rd_go || launch),
		.count_i (rd_go ? 3'(READ_STALL) : 3'(PROG_STALL)),   // RQ4 RQ5
		.stall_o (stall_o)
	);

	//--------------------------------------------------------------------------
	// read port and interrupt
	//--------------------------------------------------------------------------
	// registered read data; reserved bits read zero
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= ZERO_BYTE;
		end else if (rd_i) begin
			unique case (addr_i)
				ADDR_OFS: rdata_o <= 8'(store_address_reg);
				DATA_OFS: rdata_o <= store_data_reg;
				CTRL_OFS: rdata_o <= {2'h0, program_mode_field, ready_irq_enable,
				                      arm, program_strobe, 1'b0};   // RQ3
				default:  rdata_o <= ZERO_BYTE;
			endcase
		end else begin
			rdata_o <= ZERO_BYTE;
		end
	end

	// level request while idle (RQ19)
	assign irq_o = ready_irq_enable && !program_strobe;   // RQ19

	//--------------------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------------------
	// core stall: lengths follow the loads, and nothing else raises it
	a_read_stall: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ4
		rd_go |=> stall_o [*4] ##1 !stall_o)
		else $error("read stall not four");
	a_prog_stall: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ5
		launch |=> stall_o [*2] ##1 !stall_o)
		else $error("program stall not two");
	a_stall_idle: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ4 RQ5
		(!rd_go && !launch && !stall_o) |=> !stall_o)
		else $error("stall without cause");

	// busy strobe over the life of an operation
	a_launch_busy: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ7
		launch |=> program_strobe && tmr_busy)
		else $error("launch not busy");
	a_strobe_holds: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ8
		(program_strobe && tmr_busy && !tmr_done) |=> program_strobe)
		else $error("strobe dropped early");
	a_erase_end: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ11
		tmr_done |=> !program_strobe)
		else $error("strobe not cleared");
	// a core reset must not end the op; only power-on may
	a_reset_hold: assert property (@(posedge mclk_i) disable iff (!por_n_i) // RQ15
		(program_strobe && !resetn_i && !tmr_done) |=> program_strobe)
		else $error("reset aborted programming");

	// refusals while busy
	a_busy_refuse: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ9
		program_strobe |-> !rd_go && !launch)
		else $error("access while busy");
	a_busy_addr: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ9
		(program_strobe && wr_i && is_ofs(addr_i, ADDR_OFS)) |=> store_address_reg == $past(store_address_reg))
		else $error("address changed while busy");
	a_busy_mode: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ9
		(program_strobe && wr_ctrl) |=> program_mode_field == $past(program_mode_field))
		else $error("mode changed while busy");

	// store contents at the end of each kind of operation
	a_atomic_val: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ7
		(tmr_done && program_strobe && op_mode == MODE_ATOMIC) |=> mem[$past(op_addr)] == $past(op_data))
		else $error("atomic byte not stored");
	a_erase_val: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ10
		(tmr_done && program_strobe && op_mode == MODE_ERASE) |=> mem[$past(op_addr)] == ERASED_BYTE)
		else $error("erase not ff");
	a_write_val: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ12
		(tmr_done && program_strobe && op_mode == MODE_WRITE)
		|=> mem[$past(op_addr)] == ($past(mem[op_addr]) & $past(op_data)))
		else $error("write-only byte wrong");
	a_read_load: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ18
		rd_go |=> store_data_reg == mem[$past(store_address_reg)])
		else $error("read did not load data");

	// arming and the reserved mode
	a_arm_expire: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ17
		(wr_ctrl && wdata_i[ARM_BIT] && !program_strobe) ##1 (!wr_ctrl) [*4] |=> !arm)
		else $error("arm outlived four cycles");
	a_arm_gate: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ17
		(wr_ctrl && wdata_i[PROG_BIT] && !arm && !program_strobe) |=> !program_strobe)
		else $error("unarmed strobe launched");
	a_reserved_none: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ20
		(wr_ctrl && wdata_i[PROG_BIT] && program_mode_field == MODE_RESERVE && !program_strobe) |=> !program_strobe)
		else $error("reserved mode launched");

	// ready interrupt level
	a_irq_level: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ19
		irq_o == (ready_irq_enable && !program_strobe))
		else $error("irq level wrong");
	a_irq_ready: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RQ19
		(tmr_done && program_strobe && ready_irq_enable && !wr_ctrl) |=> irq_o)
		else $error("irq not raised when ready");

	//--------------------------------------------------------------------------
	// cover points
	//--------------------------------------------------------------------------
	c_atomic: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		launch && program_mode_field == MODE_ATOMIC);
	c_erase:  cover property (@(posedge mclk_i) disable iff (!resetn_i)
		launch && program_mode_field == MODE_ERASE);
	c_write:  cover property (@(posedge mclk_i) disable iff (!resetn_i)
		launch && program_mode_field == MODE_WRITE);
	c_read:   cover property (@(posedge mclk_i) disable iff (!resetn_i) rd_go);
	// core reset arriving in the middle of a running operation
	c_reset_busy: cover property (@(posedge mclk_i) disable iff (!por_n_i)
		program_strobe && !resetn_i);
endmodule // bea_ctrl

// *** bea_pkg.sv ***
//------------------------------------------------------------------------------
// Function
// RQ1: sixty-four individually accessible byte locations
// RQ2: address, data, control reachable as registers
// RQ3: self-timed programming with pollable busy strobe
// RQ4: byte read stalls core four cycles
// RQ5: program launch stalls core two cycles
// RQ6: software loads address and data first
// RQ7: mode zero, armed strobe starts erase-write
// RQ8: strobe reads one through whole atomic operation
// RQ9: busy store refuses reads and programming
// RQ10: mode one, armed strobe erases only
// RQ11: strobe stays one until erase ends
// RQ12: mode two, armed strobe writes only
// RQ13: software erases before write-only use
// RQ14: programming time from calibrated core clock
// RQ15: reset never aborts running programming
// RQ16: times 3.4 ms, 1.8 ms; mode three reserved
// RQ17: arm self-clears after four; unarmed strobe ignored
// RQ18: read strobe loads data register at once
// RQ19: ready interrupt level while idle and enabled
// RQ20: reserved mode strobe starts nothing
//------------------------------------------------------------------------------
package bea_pkg;

	// register offsets
	localparam logic [1:0] ADDR_OFS = 2'h0;     // store_address_reg
	localparam logic [1:0] DATA_OFS = 2'h1;     // store_data_reg
	localparam logic [1:0] CTRL_OFS = 2'h2;     // store_control_reg

	// control field positions
	localparam int READ_BIT = 0;                // read_strobe
	localparam int PROG_BIT = 1;                // program_strobe
	localparam int ARM_BIT  = 2;                // arm bit
	localparam int IRQE_BIT = 3;                // ready_irq_enable
	localparam int MODE_LO  = 4;                // program_mode_field low bit
	localparam int MODE_HI  = 5;

	// program_mode_field encodings
	localparam logic [1:0] MODE_ATOMIC  = 2'h0;
	localparam logic [1:0] MODE_ERASE   = 2'h1;
	localparam logic [1:0] MODE_WRITE   = 2'h2;
	localparam logic [1:0] MODE_RESERVE = 2'h3;

	// timing
	localparam int CLK_HZ        = 20_000_000;
	localparam int ATOMIC_US     = 3400;        // 3.4 ms
	localparam int SPLIT_US      = 1800;        // 1.8 ms
	localparam int ATOMIC_CYC    = ATOMIC_US * (CLK_HZ / 1_000_000);
	localparam int SPLIT_CYC     = SPLIT_US * (CLK_HZ / 1_000_000);
	localparam int ARM_CYC       = 4;
	localparam int READ_STALL    = 4;
	localparam int PROG_STALL    = 2;

	localparam logic [7:0] ERASED_BYTE = 8'hff;  // value of an erased cell
	localparam logic [7:0] ZERO_BYTE   = 8'h00;

endpackage : bea_pkg

// *** bea_stall.sv ***
`timescale 1ns/10ps
// stall counter: holds the core for a loaded number of cycles
module bea_stall
	import bea_pkg::*;
#(
	parameter int W = 3
) (
	input  wire logic         mclk_i,
	input  wire logic         resetn_i,
	input  wire logic         load_i,   // start a stall
	input  wire logic [W-1:0] count_i,  // cycles to stall
	output logic              stall_o   // core halted
);
	logic [W-1:0] remain;               // cycles left

	initial begin
		if (W < 2) $error("stall width too small");
	end

	// countdown; a new load restarts it
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			remain <= '0;
		end else if (load_i) begin
			remain <= count_i;
		end else if (remain != '0) begin
			remain <= remain - W'(1);
		end
	end

	assign stall_o = (remain != '0);
endmodule // bea_stall

// *** bea_timer.sv ***
`timescale 1ns/10ps
// programming timer on the calibrated core clock; ignores core reset on purpose
module bea_timer
	import bea_pkg::*;
#(
	parameter int W = 17
) (
	input  wire logic         mclk_i,
	input  wire logic         por_n_i,  // power-on clear only
	input  wire logic         start_i,  // launch a timed operation
	input  wire logic [W-1:0] cycles_i, // operation length in cycles
	output logic              busy_o,   // operation running
	output logic              done_o    // one-cycle pulse at the end
);
	logic [W-1:0] remain;               // cycles left

	initial begin
		if (W < 2) $error("timer width too small");
	end

	// duration counted in core clocks (RQ14)
	always_ff @(posedge mclk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			remain <= '0;
		end else if (start_i && remain == '0) begin
			remain <= cycles_i;                 // RQ14
		end else if (remain != '0) begin
			remain <= remain - W'(1);
		end
	end

	assign busy_o = (remain != '0);
	assign done_o = (remain == W'(1));
endmodule // bea_timer

// *** bea_core_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// core model: register writes and reads, then sits out any stall
// ----------------------------------------------------------------
module bea_core_model
	import bea_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       stall_i,
	output logic      [1:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o
);
	// bus idle at time zero
	initial begin
		addr_o  = 2'h0;
		wdata_o = 8'h00;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
	end

	// one write cycle; st returns how long the core was held
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d, output int st);
		@(posedge mclk_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge mclk_i);
		wr_o    <= 1'b0;
		// released lines flip so stale values never pass for data
		addr_o  <= ~a;
		wdata_o <= ~d;
		st = 0;
		// no new request while the core is halted
		for (int i = 0; i < 8; i++) begin
			@(negedge mclk_i);
			if (stall_i !== 1'b1) break;
			st++;
		end
	endtask

	// one read cycle; data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge mclk_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		@(negedge mclk_i);
		d = rdata_i;
	endtask
endmodule // bea_core_model

// *** tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
// ----------------------------------------------------------------
// bench: core model drives the register port, tasks judge results
// ----------------------------------------------------------------
module tb;
	import bea_pkg::*;
	localparam int AL = 30; // shortened atomic time keeps the run short
	localparam int SL = 10; // shortened split time
	logic       mclk_i;
	logic       resetn_i;
	logic       por_n_i;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       wr;
	logic       rd;
	logic       stall;
	logic       irq;
	int         n_fail = 0;
	int         check_count = 0;

	bea_ctrl #(.DEPTH(64), .ATOMIC_LEN(AL), .SPLIT_LEN(SL)) dut_u (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .por_n_i(por_n_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .stall_o(stall), .irq_o(irq));
	bea_core_model core_u (.mclk_i(mclk_i), .rdata_i(rdata), .stall_i(stall), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// poll the strobe under a bound; a hang ends the run
	task automatic wait_idle();
		logic [7:0] v;
		for (int i = 0; i < 100; i++) begin
			core_u.reg_rd(CTRL_OFS, v);
			if (v[PROG_BIT] === 1'b0) return;
		end
		n_fail++;
		$display("mismatch idle wait exp 0 got 1");
		end_of_test();
	endtask

	// address and data first, then arm, then arm with strobe
	task automatic launch(input logic [5:0] a, input logic [7:0] d, input logic [1:0] m, input logic ie,
		output int st);
		int s;
		core_u.reg_wr(ADDR_OFS, {2'h0, a}, s);
		core_u.reg_wr(DATA_OFS, d, s);
		core_u.reg_wr(CTRL_OFS, {2'h0, m, ie, 3'h4}, s);
		core_u.reg_wr(CTRL_OFS, {2'h0, m, ie, 3'h6}, st);
	endtask

	task automatic read_byte(input logic [5:0] a, output logic [7:0] d, output int st);
		int s;
		core_u.reg_wr(ADDR_OFS, {2'h0, a}, s);
		core_u.reg_wr(CTRL_OFS, 8'h01, st);
		core_u.reg_rd(DATA_OFS, d);
	endtask

	// strobe still set a little before len, clear a little after
	task automatic check_len(input int len);
		logic [7:0] v;
		repeat (len - 8) @(posedge mclk_i);
		core_u.reg_rd(CTRL_OFS, v);
		`CHK("busy strobe", 1'b1, v[PROG_BIT])
		repeat (8) @(posedge mclk_i);
		core_u.reg_rd(CTRL_OFS, v);
		`CHK("strobe cleared", 1'b0, v[PROG_BIT])
	endtask

	task automatic t_reset();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			core_u.reg_rd(2'(i), v);
			`CHK("reset value", 8'h00, v)
		end
		$display("test reset done");
	endtask

	task automatic t_atomic();
		logic [7:0] v;
		int         st;
		launch(6'h3f, 8'ha5, MODE_ATOMIC, 1'b0, st);
		`CHK("launch stall", 2, st)
		check_len(AL);
		read_byte(6'h3f, v, st);
		`CHK("read stall", 4, st)
		`CHK("atomic byte", 8'ha5, v)
		$display("test atomic done");
	endtask

	task automatic t_split();
		logic [7:0] v;
		int         st;
		launch(6'h05, 8'h00, MODE_ERASE, 1'b0, st);
		check_len(SL);
		read_byte(6'h05, v, st);
		`CHK("erased byte", ERASED_BYTE, v)
		// cell was erased just above, so write-only is legal
		launch(6'h05, 8'h3c, MODE_WRITE, 1'b0, st);
		check_len(SL);
		read_byte(6'h05, v, st);
		`CHK("written byte", 8'h3c, v)
		$display("test split done");
	endtask

	task automatic t_ignore();
		logic [7:0] v;
		int         st;
		core_u.reg_wr(CTRL_OFS, 8'h02, st);
		core_u.reg_rd(CTRL_OFS, v);
		`CHK("unarmed strobe", 1'b0, v[PROG_BIT])
		core_u.reg_wr(CTRL_OFS, 8'h04, st);
		core_u.reg_rd(CTRL_OFS, v);
		`CHK("arm set", 1'b1, v[ARM_BIT])
		repeat (4) @(posedge mclk_i);
		core_u.reg_rd(CTRL_OFS, v);
		`CHK("arm lapsed", 1'b0, v[ARM_BIT])
		core_u.reg_wr(CTRL_OFS, 8'h02, st);
		core_u.reg_rd(CTRL_OFS, v);
		`CHK("late strobe", 1'b0, v[PROG_BIT])
		launch(6'h05, 8'h00, MODE_RESERVE, 1'b0, st);
		`CHK("reserved stall", 0, st)
		core_u.reg_rd(CTRL_OFS, v);
		`CHK("reserved strobe", 1'b0, v[PROG_BIT])
		read_byte(6'h05, v, st);
		`CHK("reserved byte", 8'h3c, v)
		$display("test ignore done");
	endtask

	task automatic t_busy();
		logic [7:0] v;
		int         st;
		launch(6'h0a, 8'h5a, MODE_ATOMIC, 1'b0, st);
		core_u.reg_wr(ADDR_OFS, 8'h14, st);
		core_u.reg_rd(ADDR_OFS, v);
		`CHK("busy address", 8'h0a, v)
		core_u.reg_wr(CTRL_OFS, 8'h01, st);
		core_u.reg_rd(DATA_OFS, v);
		`CHK("busy data", 8'h5a, v)
		// core reset in mid-operation must not abort it
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		@(posedge mclk_i);
		resetn_i <= 1'b1;
		core_u.reg_rd(CTRL_OFS, v);
		`CHK("strobe over reset", 1'b1, v[PROG_BIT])
		wait_idle();
		read_byte(6'h0a, v, st);
		`CHK("byte over reset", 8'h5a, v)
		$display("test busy done");
	endtask

	task automatic t_irq();
		int st;
		core_u.reg_wr(CTRL_OFS, 8'h08, st);
		`CHK("irq idle", 1'b1, irq)
		launch(6'h01, 8'h11, MODE_ATOMIC, 1'b1, st);
		`CHK("irq busy", 1'b0, irq)
		wait_idle();
		`CHK("irq ready", 1'b1, irq)
		core_u.reg_wr(CTRL_OFS, 8'h00, st);
		`CHK("irq off", 1'b0, irq)
		$display("test irq done");
	endtask

	initial begin
		resetn_i = 1'b0;
		por_n_i  = 1'b0;
		repeat (3) @(posedge mclk_i);
		resetn_i <= 1'b1;
		por_n_i  <= 1'b1;
		t_reset();
		t_atomic();
		t_split();
		t_ignore();
		t_busy();
		t_irq();
		end_of_test();
	end
endmodule // tb
